// ### verilog/tmrc_pkg.sv
// Constants and types shared by the timer control and data register block
// Function
// - Timer 1 overflow sets bit 7, or Timer 0 high byte overflow while split, vector clears
// - Timer 0 overflow sets bit 5, vector clears
// - Timer 1 counts while bit 6 set, or without it while Timer 0 is split
// - Timer 0 counts while bit 4 set; in split mode its high byte runs on bit 6 instead
// - Pin 1 edge or level sets bit 3
// - Pin 0 edge or level sets bit 1
// - Vector clears only edge flags; level follows pin
// - Bit 2 chooses edge or level for pin 1
// - Bit 0 chooses edge or level for pin 0
// - Low four control bits never touch timers
// - Timer 2 overflow sets flag unless serial clocking
// - Trigger capture or reload sets external flag
// - Receive clock select routes Timer 2 or 1
// - Transmit clock select routes Timer 2 or 1
// - Trigger enable gates trigger pin edges
// - Timer 2 runs only while start bit set
// - Function select picks pin or core clock
// - Capture select picks capture or autoreload
// - Serial clocking forces autoreload on overflow
// - Six readable writable data bytes, reset zero
// - Gating bit requires pin high to count
// - Mode 2 reloads low byte from high byte
// - Mode 0 is a 13-bit counter
// - Timer 2 rollover loads reload value, except in capture mode without serial clocking
package tmrc_pkg;
   localparam logic [7:0] ADDR_T01_CTRL = 8'h88;
   localparam logic [7:0] ADDR_T0_LOW = 8'h8a;
   localparam logic [7:0] ADDR_T1_LOW = 8'h8b;
   localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
   localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
   localparam logic [7:0] ADDR_T2_CTRL = 8'hc8;
   localparam logic [7:0] ADDR_T2_LOW = 8'hcc;
   localparam logic [7:0] ADDR_T2_HIGH = 8'hcd;
   localparam logic [7:0] REG_RESET = 8'h00;
   // Timer 0/1 control bit positions
   localparam int BIT_T1_OVF = 7;
   localparam int BIT_T1_RUN = 6;
   localparam int BIT_T0_OVF = 5;
   localparam int BIT_T0_RUN = 4;
   localparam int BIT_IRQ1_FLAG = 3;
   localparam int BIT_IRQ1_EDGE = 2;
   localparam int BIT_IRQ0_FLAG = 1;
   localparam int BIT_IRQ0_EDGE = 0;
   // Timer 2 control bit positions
   localparam int BIT_T2_OVF = 7;
   localparam int BIT_T2_EXT = 6;
   localparam int BIT_RX_CLK = 5;
   localparam int BIT_TX_CLK = 4;
   localparam int BIT_T2_TRIG_EN = 3;
   localparam int BIT_T2_RUN = 2;
   localparam int BIT_T2_COUNTER = 1;
   localparam int BIT_T2_CAPTURE = 0;
   // Mode register fields (mode register lives outside this block)
   localparam int BIT_T1_GATE = 7;
   localparam int BIT_T1_COUNTER = 6;
   localparam int POS_T1_MODE = 4;
   localparam int BIT_T0_GATE = 3;
   localparam int BIT_T0_COUNTER = 2;
   localparam int POS_T0_MODE = 0;
   localparam logic [1:0] MODE_13BIT = 2'h0;
   localparam logic [1:0] MODE_16BIT = 2'h1;
   localparam logic [1:0] MODE_RELOAD8 = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;
   // Synchronised pin indices
   localparam int NUM_PINS = 6;
   localparam int PIN_IRQ0 = 0;
   localparam int PIN_IRQ1 = 1;
   localparam int PIN_T0 = 2;
   localparam int PIN_T1 = 3;
   localparam int PIN_T2_COUNT = 4;
   localparam int PIN_T2_TRIG = 5;
   localparam logic [NUM_PINS-1:0] PINS_RESET = 6'h3f;
endpackage : tmrc_pkg

// ### verilog/tmrc_timer_regs.sv
// Timer 0/1/2 control, flag and data register logic with interrupt pin flags
`timescale 1ns/1ps
`default_nettype none
module tmrc_timer_regs
   import tmrc_pkg::*;
(
   input wire logic ref_clk, // Core clock, 10 MHz
   input wire logic reset_n, // Synchronous reset, active low
   input wire logic [7:0] sfr_addr, // Register address
   input wire logic sfr_wr, // Write strobe
   input wire logic [7:0] sfr_wdata, // Write data
   output logic [7:0] sfr_rdata, // Read data, one cycle after address
   input wire logic [7:0] timer_mode, // Mode register contents
   input wire logic [15:0] t2_reload_value, // Reload/capture register pair
   input wire logic t0_vector_ack, // Core vectors to Timer 0 service
   input wire logic t1_vector_ack, // Core vectors to Timer 1 service
   input wire logic irq0_vector_ack, // Core vectors to pin 0 service
   input wire logic irq1_vector_ack, // Core vectors to pin 1 service
   input wire logic ext_irq0_pin, // External interrupt 0 pin
   input wire logic ext_irq1_pin, // External interrupt 1 pin
   input wire logic t0_count_pin, // Timer 0 count pin
   input wire logic t1_count_pin, // Timer 1 count pin
   input wire logic t2_count_pin, // Timer 2 count pin
   input wire logic t2_trigger_pin, // Timer 2 trigger pin
   output logic t2_capture_strobe, // Capture request pulse
   output logic [15:0] t2_capture_value, // Count to capture
   output logic serial_rx_clock_tick, // Receive baud tick pulse
   output logic serial_tx_clock_tick // Transmit baud tick pulse
);

   // One step of Timer 0/1 in modes 0 to 2: {overflow, high, low}
   function automatic logic [16:0] tmrc_step(input logic [1:0] mode,
                                             input logic [7:0] tl,
                                             input logic [7:0] th,
                                             input logic inc);
      logic [13:0] c13;
      logic [16:0] r;
      c13 = {1'b0, th, tl[4:0]} + 14'h0001;
      r = {1'b0, th, tl};
      if (inc) begin
         case (mode)
            MODE_13BIT: r = {c13[13], c13[12:5], tl[7:5], c13[4:0]};
            MODE_16BIT: r = {1'b0, th, tl} + 17'h00001;
            MODE_RELOAD8: begin
               if (tl == 8'hff) begin
                  r = {1'b1, th, th};
               end else begin
                  r = {1'b0, th, tl + 8'h01};
               end
            end
            default: r = {1'b0, th, tl};
         endcase
      end
      return r;
   endfunction : tmrc_step

   // Address match for a register write
   function automatic logic tmrc_wr_hit(input logic wr, input logic [7:0] a,
                                        input logic [7:0] target);
      return wr && (a == target);
   endfunction : tmrc_wr_hit

   // Pin history: first stage, second stage and the previous second stage
   logic [NUM_PINS-1:0] meta_q, meta_d;
   logic [NUM_PINS-1:0] sync_q, sync_d;
   logic [NUM_PINS-1:0] prev_q, prev_d;
   logic [NUM_PINS-1:0] fall;

   // Control registers of Timers 0/1 and of Timer 2
   logic [7:0] ctl01_q, ctl01_d;
   logic [7:0] ctl2_q, ctl2_d;

   // Data bytes of the three timers
   logic [7:0] lo0_q, lo0_d, hi0_q, hi0_d;
   logic [7:0] lo1_q, lo1_d, hi1_q, hi1_d;
   logic [7:0] lo2_q, lo2_d, hi2_q, hi2_d;

   // Registered read data
   logic [7:0] rdata_q, rdata_d;

   // Capture request and serial baud ticks
   logic cap_q, cap_d;
   logic [15:0] capv_q, capv_d;
   logic rx_q, rx_d, tx_q, tx_d;

   // Counting intermediates, recomputed every cycle
   logic [16:0] step0, step1;
   logic [16:0] cnt2;
   logic [8:0] hi0_inc;
   logic [1:0] mode0, mode1;
   logic inc0, inc1, inc_hi0, inc2;
   logic ovf0, ovf1, ovf2, t1_ovf_raw;
   logic baud, trig, set_tf0, set_tf1, set_ie0, set_ie1;
   logic [7:0] ctl01_base, ctl2_base;

   // Pin synchroniser and edge history; first stage feeds only the second
   // The history stage exists so that an edge is judged on settled values
   always_comb begin
      meta_d = {t2_trigger_pin, t2_count_pin, t1_count_pin, t0_count_pin,
                ext_irq1_pin, ext_irq0_pin};
      sync_d = meta_q;
      prev_d = sync_q;
   end

   // Pins reset to their idle high level, so reset makes no false edge
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         meta_q <= PINS_RESET;
         sync_q <= PINS_RESET;
         prev_q <= PINS_RESET;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   // Falling edge: sampled high then sampled low
   // Lasts exactly one cycle per edge, however long the pin stays low
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_fall
         assign fall[gi] = prev_q[gi] & ~sync_q[gi];
      end
   endgenerate

   // Timer 0 and Timer 1 counting
   // A counter-mode timer advances once per synchronised falling edge
   always_comb begin
      mode0 = timer_mode[POS_T0_MODE +: 2];
      mode1 = timer_mode[POS_T1_MODE +: 2];
      // Gated enable; low four control bits are never consulted here
      inc0 = ctl01_q[BIT_T0_RUN]
             & (~timer_mode[BIT_T0_GATE] | sync_q[PIN_IRQ0])
             & (~timer_mode[BIT_T0_COUNTER] | fall[PIN_T0]);
      // With Timer 0 split, Timer 1 runs on without its own run bit
      inc1 = (ctl01_q[BIT_T1_RUN] | (mode0 == MODE_SPLIT))
             & (~timer_mode[BIT_T1_GATE] | sync_q[PIN_IRQ1])
             & (~timer_mode[BIT_T1_COUNTER] | fall[PIN_T1])
             & (mode1 != MODE_SPLIT);
      // Split mode: low byte is an 8-bit counter, high byte borrows Timer 1 run
      inc_hi0 = (mode0 == MODE_SPLIT) & ctl01_q[BIT_T1_RUN];
      hi0_inc = {1'b0, hi0_q} + {8'h00, inc_hi0};
      if (mode0 == MODE_SPLIT) begin
         step0 = {1'b0, hi0_inc[7:0], lo0_q + {7'h00, inc0}};
         ovf0 = inc0 & (lo0_q == 8'hff);
      end else begin
         step0 = tmrc_step(mode0, lo0_q, hi0_q, inc0);
         ovf0 = step0[16];
      end
      step1 = tmrc_step(mode1, lo1_q, hi1_q, inc1);
      // Raw Timer 1 overflow still clocks the serial port in split mode
      t1_ovf_raw = step1[16];
      ovf1 = (mode0 == MODE_SPLIT) ? hi0_inc[8] : t1_ovf_raw;
   end

   // Timer 2 counting, reload and capture
   // In baud mode the trigger pin only raises its flag, nothing else
   always_comb begin
      baud = ctl2_q[BIT_RX_CLK] | ctl2_q[BIT_TX_CLK];
      inc2 = ctl2_q[BIT_T2_RUN]
             & (~ctl2_q[BIT_T2_COUNTER] | fall[PIN_T2_COUNT]);
      cnt2 = {1'b0, hi2_q, lo2_q} + {16'h0000, inc2};
      ovf2 = cnt2[16];
      trig = fall[PIN_T2_TRIG] & ctl2_q[BIT_T2_TRIG_EN];
      if (ovf2 && (baud || !ctl2_q[BIT_T2_CAPTURE])) begin
         cnt2[15:0] = t2_reload_value;
      end
      if (trig && !baud && !ctl2_q[BIT_T2_CAPTURE]) begin
         cnt2[15:0] = t2_reload_value;
      end
      // Capture hands over the count as it stood before this edge
      cap_d = trig & ~baud & ctl2_q[BIT_T2_CAPTURE];
      capv_d = {hi2_q, lo2_q};
      rx_d = ctl2_q[BIT_RX_CLK] ? ovf2 : t1_ovf_raw;
      tx_d = ctl2_q[BIT_TX_CLK] ? ovf2 : t1_ovf_raw;
   end

   // Data bytes: a software write to a byte wins over counting
   // The other byte of the same timer keeps its counted value
   always_comb begin
      lo0_d = step0[7:0];
      hi0_d = step0[15:8];
      lo1_d = step1[7:0];
      hi1_d = step1[15:8];
      lo2_d = cnt2[7:0];
      hi2_d = cnt2[15:8];
      if (tmrc_wr_hit(sfr_wr, sfr_addr, ADDR_T0_LOW)) begin
         lo0_d = sfr_wdata;
      end
      if (tmrc_wr_hit(sfr_wr, sfr_addr, ADDR_T0_HIGH)) begin
         hi0_d = sfr_wdata;
      end
      if (tmrc_wr_hit(sfr_wr, sfr_addr, ADDR_T1_LOW)) begin
         lo1_d = sfr_wdata;
      end
      if (tmrc_wr_hit(sfr_wr, sfr_addr, ADDR_T1_HIGH)) begin
         hi1_d = sfr_wdata;
      end
      if (tmrc_wr_hit(sfr_wr, sfr_addr, ADDR_T2_LOW)) begin
         lo2_d = sfr_wdata;
      end
      if (tmrc_wr_hit(sfr_wr, sfr_addr, ADDR_T2_HIGH)) begin
         hi2_d = sfr_wdata;
      end
   end

   // Data byte registers
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         lo0_q <= REG_RESET;
         hi0_q <= REG_RESET;
         lo1_q <= REG_RESET;
         hi1_q <= REG_RESET;
         lo2_q <= REG_RESET;
         hi2_q <= REG_RESET;
      end else begin
         lo0_q <= lo0_d;
         hi0_q <= hi0_d;
         lo1_q <= lo1_d;
         hi1_q <= hi1_d;
         lo2_q <= lo2_d;
         hi2_q <= hi2_d;
      end
   end

   // Control registers: hardware sets win over software or vector clears
   // so that an overflow in the clearing cycle is never lost
   always_comb begin
      ctl01_base = tmrc_wr_hit(sfr_wr, sfr_addr, ADDR_T01_CTRL) ? sfr_wdata : ctl01_q;
      ctl2_base = tmrc_wr_hit(sfr_wr, sfr_addr, ADDR_T2_CTRL) ? sfr_wdata : ctl2_q;
      set_tf0 = ovf0;
      set_tf1 = ovf1;
      set_ie0 = fall[PIN_IRQ0];
      set_ie1 = fall[PIN_IRQ1];
      ctl01_d = ctl01_base;
      ctl01_d[BIT_T1_OVF] = (ctl01_base[BIT_T1_OVF] & ~t1_vector_ack) | set_tf1;
      ctl01_d[BIT_T0_OVF] = (ctl01_base[BIT_T0_OVF] & ~t0_vector_ack) | set_tf0;
      if (ctl01_q[BIT_IRQ1_EDGE]) begin
         // Edge mode: falling edge sets, vector clears
         ctl01_d[BIT_IRQ1_FLAG] = (ctl01_base[BIT_IRQ1_FLAG] & ~irq1_vector_ack)
                                  | set_ie1;
      end else begin
         // Level mode: flag follows the pin, a write to it is ignored
         ctl01_d[BIT_IRQ1_FLAG] = ~sync_q[PIN_IRQ1];
      end
      if (ctl01_q[BIT_IRQ0_EDGE]) begin
         ctl01_d[BIT_IRQ0_FLAG] = (ctl01_base[BIT_IRQ0_FLAG] & ~irq0_vector_ack)
                                  | set_ie0;
      end else begin
         ctl01_d[BIT_IRQ0_FLAG] = ~sync_q[PIN_IRQ0];
      end
      // Timer 2 flags are cleared by software only
      ctl2_d = ctl2_base;
      ctl2_d[BIT_T2_OVF] = ctl2_base[BIT_T2_OVF] | (ovf2 & ~baud);
      ctl2_d[BIT_T2_EXT] = ctl2_base[BIT_T2_EXT] | trig;
   end

   // Control register flip-flops
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ctl01_q <= REG_RESET;
         ctl2_q <= REG_RESET;
      end else begin
         ctl01_q <= ctl01_d;
         ctl2_q <= ctl2_d;
      end
   end

   // Capture request and serial tick flip-flops
   // Ticks trail the overflow that makes them by one cycle
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cap_q <= 1'b0;
         capv_q <= 16'h0000;
         rx_q <= 1'b0;
         tx_q <= 1'b0;
      end else begin
         cap_q <= cap_d;
         capv_q <= capv_d;
         rx_q <= rx_d;
         tx_q <= tx_d;
      end
   end

   // Read multiplexer, registered; unmapped addresses read zero
   // The mode register and reload pair live elsewhere and read zero here
   always_comb begin
      if (sfr_addr == ADDR_T01_CTRL) begin
         rdata_d = ctl01_q;
      end else if (sfr_addr == ADDR_T0_LOW) begin
         rdata_d = lo0_q;
      end else if (sfr_addr == ADDR_T1_LOW) begin
         rdata_d = lo1_q;
      end else if (sfr_addr == ADDR_T0_HIGH) begin
         rdata_d = hi0_q;
      end else if (sfr_addr == ADDR_T1_HIGH) begin
         rdata_d = hi1_q;
      end else if (sfr_addr == ADDR_T2_CTRL) begin
         rdata_d = ctl2_q;
      end else if (sfr_addr == ADDR_T2_LOW) begin
         rdata_d = lo2_q;
      end else if (sfr_addr == ADDR_T2_HIGH) begin
         rdata_d = hi2_q;
      end else begin
         rdata_d = 8'h00;
      end
   end

   // Read data flip-flop: shows the value from before this edge's update
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rdata_q <= REG_RESET;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // Outputs straight from flip-flops
   assign sfr_rdata = rdata_q;
   assign t2_capture_strobe = cap_q;
   assign t2_capture_value = capv_q;
   assign serial_rx_clock_tick = rx_q;
   assign serial_tx_clock_tick = tx_q;

endmodule : tmrc_timer_regs
`default_nettype wire

// ### testbench/tmrc_timer_regs_checker.sv
// Port assertions for the timer control and data register block
`timescale 1ns/1ps
`default_nettype none
module tmrc_timer_regs_checker
   import tmrc_pkg::*;
(
   input wire logic ref_clk, // Core clock
   input wire logic reset_n, // Synchronous reset, active low
   input wire logic [7:0] sfr_addr, // Register address
   input wire logic sfr_wr, // Write strobe
   input wire logic [7:0] sfr_wdata, // Write data
   input wire logic [7:0] sfr_rdata, // Read data
   input wire logic [7:0] timer_mode, // Mode register contents
   input wire logic ext_irq0_pin, // Interrupt pin 0
   input wire logic ext_irq1_pin, // Interrupt pin 1
   input wire logic t2_capture_strobe // Capture pulse
);
   logic t1_held;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // Timer 1 parked in its hold mode with Timer 0 not split
   assign t1_held = timer_mode[5:4] == MODE_SPLIT && timer_mode[1:0] != MODE_SPLIT;
   property p_unmapped;
      sfr_addr == 8'h89 |=> sfr_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_ctrl01;
      (sfr_wr && sfr_addr == ADDR_T01_CTRL) ##1 (!sfr_wr && sfr_addr == ADDR_T01_CTRL)
         |=> (sfr_rdata & 8'h55) == ($past(sfr_wdata, 2) & 8'h55);
   endproperty
   a_ctrl01: assert property (p_ctrl01)
      else $error("timer01 control bits lost");
   property p_ctrl2;
      (sfr_wr && sfr_addr == ADDR_T2_CTRL) ##1 (!sfr_wr && sfr_addr == ADDR_T2_CTRL)
         |=> sfr_rdata[5:0] == $past(sfr_wdata[5:0], 2);
   endproperty
   a_ctrl2: assert property (p_ctrl2)
      else $error("timer2 control bits lost");
   property p_hold1;
      (sfr_wr && sfr_addr == ADDR_T1_HIGH && t1_held)
         ##1 (!sfr_wr && sfr_addr == ADDR_T1_HIGH && t1_held) |=> sfr_rdata == $past(sfr_wdata, 2);
   endproperty
   a_hold1: assert property (p_hold1)
      else $error("timer1 high byte not kept");
   property p_lvl0_hi;
      (sfr_addr == ADDR_T01_CTRL && !sfr_wr && ext_irq0_pin) [*6] |=> sfr_rdata[0] || !sfr_rdata[1];
   endproperty
   a_lvl0_hi: assert property (p_lvl0_hi)
      else $error("level flag 0 set with pin high");
   property p_lvl0_lo;
      (sfr_addr == ADDR_T01_CTRL && !sfr_wr && !ext_irq0_pin) [*6] |=> sfr_rdata[0] || sfr_rdata[1];
   endproperty
   a_lvl0_lo: assert property (p_lvl0_lo)
      else $error("level flag 0 clear with pin low");
   property p_lvl1_hi;
      (sfr_addr == ADDR_T01_CTRL && !sfr_wr && ext_irq1_pin) [*6] |=> sfr_rdata[2] || !sfr_rdata[3];
   endproperty
   a_lvl1_hi: assert property (p_lvl1_hi)
      else $error("level flag 1 set with pin high");
   property p_strobe;
      t2_capture_strobe |=> !t2_capture_strobe;
   endproperty
   a_strobe: assert property (p_strobe)
      else $error("capture strobe too long");
endmodule : tmrc_timer_regs_checker
bind tmrc_timer_regs tmrc_timer_regs_checker u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
   .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
   .timer_mode(timer_mode), .ext_irq0_pin(ext_irq0_pin), .ext_irq1_pin(ext_irq1_pin),
   .t2_capture_strobe(t2_capture_strobe));
`default_nettype wire

// ### testbench/tmrc_pin_model.sv
// External pin model: interrupt, count and trigger pins
`timescale 1ns/1ps
`default_nettype none
module tmrc_pin_model
   import tmrc_pkg::*;
(
   input wire logic ref_clk, // Core clock
   output logic [NUM_PINS-1:0] pins // Pin levels
);
   // Pins idle high
   initial pins = PINS_RESET;
   // Hold a pin low long enough to be seen, then release it
   task automatic fall(input int i);
      @(posedge ref_clk);
      #10;
      pins[i] = 1'b0;
      repeat (4) @(posedge ref_clk);
      #10;
      pins[i] = 1'b1;
   endtask : fall
   task automatic set_pin(input int i, input logic v);
      @(posedge ref_clk);
      #10;
      pins[i] = v;
   endtask : set_pin
endmodule : tmrc_pin_model
`default_nettype wire

// ### testbench/tb_tmrc_timer_regs.sv
// Testbench for the timer control and data register block
`timescale 1ns/1ps
`default_nettype none
module tb_tmrc_timer_regs
   import tmrc_pkg::*;
;
   logic ref_clk, reset_n, sfr_wr, t2_capture_strobe, rx_tick, tx_tick;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, timer_mode, v;
   logic [15:0] t2_reload_value, t2_capture_value, cap_v;
   logic [3:0] acks;
   logic [NUM_PINS-1:0] pins;
   int failures = 0, num_checks = 0, rx_n = 0, tx_n = 0, cap_n = 0, r, t;
   logic [7:0] regs [8] = '{ADDR_T01_CTRL, ADDR_T0_LOW, ADDR_T1_LOW, ADDR_T0_HIGH,
      ADDR_T1_HIGH, ADDR_T2_CTRL, ADDR_T2_LOW, ADDR_T2_HIGH};
   tmrc_timer_regs u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer_mode(timer_mode),
      .t2_reload_value(t2_reload_value), .t0_vector_ack(acks[0]), .t1_vector_ack(acks[1]),
      .irq0_vector_ack(acks[2]), .irq1_vector_ack(acks[3]), .ext_irq0_pin(pins[PIN_IRQ0]),
      .ext_irq1_pin(pins[PIN_IRQ1]), .t0_count_pin(pins[PIN_T0]), .t1_count_pin(pins[PIN_T1]),
      .t2_count_pin(pins[PIN_T2_COUNT]), .t2_trigger_pin(pins[PIN_T2_TRIG]),
      .t2_capture_strobe(t2_capture_strobe), .t2_capture_value(t2_capture_value),
      .serial_rx_clock_tick(rx_tick), .serial_tx_clock_tick(tx_tick));
   tmrc_pin_model u_pins (.ref_clk(ref_clk), .pins(pins));
   // 10 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // Count tick and capture pulses
   always @(posedge ref_clk) begin
      if (rx_tick === 1'b1) rx_n++;
      if (tx_tick === 1'b1) tx_n++;
      if (t2_capture_strobe === 1'b1) begin
         cap_n++;
         cap_v = t2_capture_value;
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #10;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge ref_clk);
      #10;
      sfr_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      #10;
      sfr_addr = a;
      @(posedge ref_clk);
      #10;
      d = sfr_rdata;
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      chk(16'(d), 16'(e));
   endtask : rchk
   task automatic ack(input int i);
      @(posedge ref_clk);
      #10;
      acks[i] = 1'b1;
      @(posedge ref_clk);
      #10;
      acks[i] = 1'b0;
   endtask : ack
   task automatic tally_and_finish;
      if (failures == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   // Watchdog
   initial begin
      #2000000;
      failures++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      {reset_n, sfr_wr, sfr_addr, sfr_wdata, acks} = '0;
      timer_mode = 8'h30;
      t2_reload_value = 16'hfff0;
      repeat (5) @(posedge ref_clk);
      #10;
      reset_n = 1'b1;
      for (int i = 0; i < 8; i++) rchk(regs[i], REG_RESET);
      for (int i = 1; i < 8; i++) if (i != 5) begin
         wr(regs[i], 8'(8'h11 * i));
         rchk(regs[i], 8'(8'h11 * i));
      end
      rchk(8'h89, 8'h00);
      // Timer 0 13-bit rollover and vector clear
      timer_mode = 8'h00;
      wr(ADDR_T0_HIGH, 8'hff);
      wr(ADDR_T0_LOW, 8'h1f);
      wr(ADDR_T01_CTRL, 8'h10);
      rchk(ADDR_T01_CTRL, 8'h30);
      ack(0);
      rchk(ADDR_T01_CTRL, 8'h10);
      wr(ADDR_T01_CTRL, 8'h05);
      rd(ADDR_T0_LOW, v);
      rchk(ADDR_T0_LOW, v);
      // Gated Timer 0 with pin 0 in level mode
      timer_mode = 8'h09;
      u_pins.set_pin(PIN_IRQ0, 1'b0);
      wr(ADDR_T01_CTRL, 8'h10);
      rd(ADDR_T0_LOW, v);
      rchk(ADDR_T0_LOW, v);
      rchk(ADDR_T01_CTRL, 8'h12);
      repeat (7) @(posedge ref_clk);
      u_pins.set_pin(PIN_IRQ0, 1'b1);
      repeat (8) @(posedge ref_clk);
      rchk(ADDR_T01_CTRL, 8'h10);
      rd(ADDR_T0_LOW, v);
      rchk(ADDR_T0_LOW, 8'(v + 8'h02));
      // Timer 1 8-bit reload feeding both serial ticks
      timer_mode = 8'h20;
      wr(ADDR_T01_CTRL, 8'h00);
      wr(ADDR_T1_HIGH, 8'hf0);
      wr(ADDR_T1_LOW, 8'hf0);
      wr(ADDR_T01_CTRL, 8'h40);
      r = rx_n;
      t = tx_n;
      repeat (40) @(posedge ref_clk);
      chk(16'(rx_n - r), 16'h0002);
      chk(16'(tx_n - t), 16'h0002);
      rchk(ADDR_T1_HIGH, 8'hf0);
      rd(ADDR_T1_LOW, v);
      chk(16'(v[7:4]), 16'h000f);
      rchk(ADDR_T01_CTRL, 8'hc0);
      wr(ADDR_T01_CTRL, 8'h80);
      ack(1);
      rchk(ADDR_T01_CTRL, 8'h00);
      // Edge-triggered interrupt pins
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_T01_CTRL, 8'h05);
         u_pins.fall(i);
         repeat (4) @(posedge ref_clk);
         rchk(ADDR_T01_CTRL, 8'(8'h02 << (2 * i)) | 8'h05);
         ack(2 + i);
         rchk(ADDR_T01_CTRL, 8'h05);
      end
      // Timer 2 autoreload, then serial clocking
      wr(ADDR_T01_CTRL, 8'h00);
      wr(ADDR_T2_LOW, 8'hfe);
      wr(ADDR_T2_HIGH, 8'hff);
      wr(ADDR_T2_CTRL, 8'h04);
      repeat (20) @(posedge ref_clk);
      rchk(ADDR_T2_CTRL, 8'h84);
      rd(ADDR_T2_LOW, v);
      chk(16'(v[7:4]), 16'h000f);
      wr(ADDR_T2_CTRL, 8'h34);
      r = rx_n;
      t = tx_n;
      repeat (32) @(posedge ref_clk);
      chk(16'(rx_n - r), 16'h0002);
      chk(16'(tx_n - t), 16'h0002);
      rchk(ADDR_T2_CTRL, 8'h34);
      // Timer 2 counting pin events, then capture and trigger reload
      wr(ADDR_T2_CTRL, 8'h00);
      wr(ADDR_T2_LOW, 8'h00);
      wr(ADDR_T2_HIGH, 8'h00);
      wr(ADDR_T2_CTRL, 8'h06);
      for (int i = 0; i < 3; i++) u_pins.fall(PIN_T2_COUNT);
      repeat (4) @(posedge ref_clk);
      rchk(ADDR_T2_LOW, 8'h03);
      wr(ADDR_T2_CTRL, 8'h09);
      r = cap_n;
      u_pins.fall(PIN_T2_TRIG);
      repeat (4) @(posedge ref_clk);
      chk(16'(cap_n - r), 16'h0001);
      chk(cap_v, 16'h0003);
      rchk(ADDR_T2_CTRL, 8'h49);
      wr(ADDR_T2_CTRL, 8'h01);
      u_pins.fall(PIN_T2_TRIG);
      repeat (4) @(posedge ref_clk);
      chk(16'(cap_n - r), 16'h0001);
      rchk(ADDR_T2_CTRL, 8'h01);
      wr(ADDR_T2_CTRL, 8'h08);
      u_pins.fall(PIN_T2_TRIG);
      repeat (4) @(posedge ref_clk);
      rchk(ADDR_T2_LOW, 8'hf0);
      rchk(ADDR_T2_CTRL, 8'h48);
      tally_and_finish();
   end
endmodule : tb_tmrc_timer_regs
`default_nettype wire
